// ---- shared/ts_sublayer_consts.svh ----
// field positions, lengths and codes of the multichannel transport sublayer
`ifndef TS_SUBLAYER_CONSTS_SVH
`define TS_SUBLAYER_CONSTS_SVH

// ----------------------------------------
// frame geometry
// ----------------------------------------
`define SUB_LEN 5'h04
`define ARRAY_LEN 5'h14
`define HDR_LAST 5'h17
`define TS_LEN 8'hBC
`define TS_LAST 8'hBB
`define MAX_PKTS 4'hA

// ----------------------------------------
// bit positions in subheader bytes zero and one and in entry bytes, msb first
// ----------------------------------------
`define CONN_BIT 7
`define SEQV_BIT 6
`define HT_HI 5
`define HT_LO 4
`define SPARE_BIT 3
`define SEL_HI 2
`define SEL_LO 0
`define TOTAL_HI 3
`define TOTAL_LO 0
`define ESEQ_HI 7
`define ESEQ_LO 4

// ----------------------------------------
// header type codes, null packet content and session sequence half range
// ----------------------------------------
`define HT_DATA 2'h0
`define HT_PROBE 2'h1
`define TS_SYNC 8'h47
`define NULL_PID 13'h1FFF
`define NULL_AFC 8'h10
`define NULL_FILL 8'hFF
`define HALF_SEQ 16'h8000

`endif

// ---- shared/ts_sublayer_pkg.sv ----
// types shared by the transport sublayer receiver
package ts_sublayer_pkg;

    typedef logic [7:0] byte_t;

    // parser states
    typedef enum logic [1:0]
    {
        ST_HDR = 2'b00,
        ST_PAY = 2'b01,
        ST_DROP = 2'b10
    } rx_state_e;

endpackage

// ---- verilog/ts_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ts_fifo
#(
    parameter int WIDTH = 19,
    parameter int DEPTH = 32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign wr_ready = !full;
    assign rd_valid = !empty;
    assign rd_data = mem_r[rd_ptr_r[AW-1:0]];

    // storage needs no reset, only the pointers define content
    always_ff @(posedge clk)
    begin
        if (wr_valid && !full)
            mem_r[wr_ptr_r[AW-1:0]] <= wr_data;
    end

    // pointers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (wr_valid && !full)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (rd_ready && !empty)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule

// ---- verilog/null_ts_rom.sv ----
// content of a 188-byte null transport packet by byte index
`timescale 1ns/1ps
`include "ts_sublayer_consts.svh"
module null_ts_rom
(
    input wire logic [7:0] idx,
    output logic [7:0] data
);
    localparam logic [12:0] PID = `NULL_PID;

    // sync, pid 0x1FFF, payload-only marker, then stuffing
    always_comb
    begin
        case (idx)
            8'h00: data = `TS_SYNC;
            8'h01: data = {3'h0, PID[12:8]};
            8'h02: data = PID[7:0];
            8'h03: data = `NULL_AFC;
            default: data = `NULL_FILL;
        endcase
    end
endmodule

// ---- verilog/ts_sublayer_rx.sv ----
// receiver of the multichannel transport sublayer: parse, steer, count, null-substitute
//
// Notes on behaviour
// - session sequence checked only when valid bit set
// - spare and reserved bits ignored on receive
// - three-bit stream selector extracted from byte zero
// - packet total 1..10 legal, others rejected
// - session sequence gaps and misorders are reported
// - tag steers each packet to its engine
// - per-channel packet counting by tag and sequence
// - per-channel null packet substitution available
// - header is 4-byte subheader plus 20-byte array
// - only first total entries are used
// - entries beyond total are ignored
// - channel gaps flagged against session frame loss
// - each payload segment is 188 bytes
// - null packet is 188 bytes, pid 0x1FFF
// - header type 01 decoded as latency probe
// - frames failing the header check are dropped, as are bytes past the total
`timescale 1ns/1ps
`include "ts_sublayer_consts.svh"
module ts_sublayer_rx
    import ts_sublayer_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    input wire logic in_last,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic out_first,
    output logic out_last,
    output logic [7:0] out_tag,
    output logic out_is_null,
    input wire logic null_on_gap,
    input wire logic null_we,
    input wire logic [7:0] null_chan,
    input wire logic null_force,
    input wire logic [7:0] cnt_sel,
    output logic [15:0] cnt_value,
    output logic [15:0] chan_lost_value,
    output logic [2:0] stream_selector,
    output logic seq_gap,
    output logic seq_misorder,
    output logic [15:0] lost_frames,
    output logic fmt_error,
    output logic probe_seen,
    output logic chan_gap,
    output logic [7:0] chan_gap_tag,
    output logic chan_gap_after_loss
);
    localparam int FW = 19;

    // ----------------------------------------
    // header capture
    // ----------------------------------------
    rx_state_e st_r;
    logic [4:0] hdr_idx_r;
    byte_t b0_r;
    byte_t b1_r;
    byte_t b2_r;
    byte_t b3_r;
    byte_t tag_r [`MAX_PKTS];
    logic [3:0] eseq_r [`MAX_PKTS];
    logic [3:0] total_r;
    logic [3:0] pkt_idx_r;
    logic [7:0] pay_idx_r;
    logic fire;
    logic fifo_in_ready;
    logic hdr_end;
    logic [1:0] htype;
    logic [3:0] total;
    logic [15:0] sess_seq;
    logic hdr_good;
    logic last_pkt;
    logic pkt_end;

    // legal header: data type and packet total inside 1..10
    function automatic logic hdr_ok(input logic [1:0] ht, input logic [3:0] cnt);
        hdr_ok = (ht == `HT_DATA) && (cnt != 4'h0) && (cnt <= `MAX_PKTS);
    endfunction

    assign fire = in_valid && in_ready;
    // only the payload path is back-pressured; header bytes are always taken
    assign in_ready = (st_r != ST_PAY) || fifo_in_ready;
    assign hdr_end = (st_r == ST_HDR) && fire && (hdr_idx_r == `HDR_LAST);
    // connectivity, spare and reserved bits are never looked at
    assign htype = b0_r[`HT_HI:`HT_LO];
    assign total = b1_r[`TOTAL_HI:`TOTAL_LO];
    assign sess_seq = {b2_r, b3_r};
    assign hdr_good = hdr_ok(htype, total);
    assign last_pkt = (pkt_idx_r == total_r - 4'h1);
    assign pkt_end = (st_r == ST_PAY) && fire && (pay_idx_r == `TS_LAST);

    // header bytes and entry array
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            b0_r <= 8'h00;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            b3_r <= 8'h00;
            for (int i = 0; i < `MAX_PKTS; i++)
            begin
                tag_r[i] <= 8'h00;
                eseq_r[i] <= 4'h0;
            end
        end
        else if ((st_r == ST_HDR) && fire)
        begin
            case (hdr_idx_r)
                5'h00: b0_r <= in_data;
                5'h01: b1_r <= in_data;
                5'h02: b2_r <= in_data;
                5'h03: b3_r <= in_data;
                default:
                begin
                    // even bytes hold the tag, odd bytes the nibble in the upper half
                    if (!hdr_idx_r[0])
                        tag_r[4'((hdr_idx_r - `SUB_LEN) >> 1)] <= in_data;
                    else
                        eseq_r[4'((hdr_idx_r - `SUB_LEN) >> 1)] <= in_data[`ESEQ_HI:`ESEQ_LO];
                end
            endcase
        end
    end

    // ----------------------------------------
    // frame state machine
    // ----------------------------------------
    logic fmt_error_r;
    logic probe_seen_r;
    logic [2:0] selector_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= ST_HDR;
            hdr_idx_r <= 5'h00;
            pay_idx_r <= 8'h00;
            pkt_idx_r <= 4'h0;
            total_r <= 4'h0;
            fmt_error_r <= 1'b0;
            probe_seen_r <= 1'b0;
            selector_r <= 3'h0;
        end
        else
        begin
            fmt_error_r <= 1'b0;
            probe_seen_r <= 1'b0;
            case (st_r)
                ST_HDR:
                begin
                    if (fire)
                    begin
                        hdr_idx_r <= hdr_idx_r + 5'h01;
                        if (hdr_end && (htype == `HT_PROBE))
                            probe_seen_r <= 1'b1;
                        if (in_last)
                        begin
                            // a frame ending inside the header carries no packet
                            hdr_idx_r <= 5'h00;
                            fmt_error_r <= !(hdr_end && (htype == `HT_PROBE));
                        end
                        else if (hdr_end)
                        begin
                            hdr_idx_r <= 5'h00;
                            pay_idx_r <= 8'h00;
                            pkt_idx_r <= 4'h0;
                            total_r <= total;
                            if (hdr_good)
                            begin
                                st_r <= ST_PAY;
                                selector_r <= b0_r[`SEL_HI:`SEL_LO];
                            end
                            else
                            begin
                                st_r <= ST_DROP;
                                fmt_error_r <= (htype != `HT_PROBE);
                            end
                        end
                    end
                end
                ST_PAY:
                begin
                    if (fire)
                    begin
                        pay_idx_r <= pkt_end ? 8'h00 : pay_idx_r + 8'h01;
                        if (pkt_end)
                            pkt_idx_r <= pkt_idx_r + 4'h1;
                        if (in_last)
                        begin
                            st_r <= ST_HDR;
                            fmt_error_r <= !(pkt_end && last_pkt);
                        end
                        else if (pkt_end && last_pkt)
                        begin
                            // more bytes than the total announces
                            st_r <= ST_DROP;
                            fmt_error_r <= 1'b1;
                        end
                    end
                end
                ST_DROP:
                begin
                    if (fire && in_last)
                        st_r <= ST_HDR;
                end
                default: st_r <= ST_HDR;
            endcase
        end
    end

    // ----------------------------------------
    // session sequence tracking
    // ----------------------------------------
    logic [15:0] sess_exp_r;
    logic sess_have_r;
    logic seq_gap_r;
    logic seq_misorder_r;
    logic [15:0] lost_frames_r;
    logic loss_pending_r;
    logic [15:0] sess_diff;

    assign sess_diff = sess_seq - sess_exp_r;

    // a backward or repeated step is misorder; a forward jump counts lost frames
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sess_exp_r <= 16'h0000;
            sess_have_r <= 1'b0;
            seq_gap_r <= 1'b0;
            seq_misorder_r <= 1'b0;
            lost_frames_r <= 16'h0000;
            loss_pending_r <= 1'b0;
        end
        else
        begin
            seq_gap_r <= 1'b0;
            seq_misorder_r <= 1'b0;
            if (hdr_end && hdr_good && !in_last && b0_r[`SEQV_BIT])
            begin
                sess_have_r <= 1'b1;
                loss_pending_r <= 1'b0;
                if (!sess_have_r || (sess_diff == 16'h0000))
                    sess_exp_r <= sess_seq + 16'h0001;
                else if (sess_diff < `HALF_SEQ)
                begin
                    seq_gap_r <= 1'b1;
                    lost_frames_r <= lost_frames_r + sess_diff;
                    loss_pending_r <= 1'b1;
                    sess_exp_r <= sess_seq + 16'h0001;
                end
                else
                    seq_misorder_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // per-channel counting and substitution
    // ----------------------------------------
    logic [15:0] pkt_cnt_r [256];
    logic [15:0] lost_cnt_r [256];
    logic [3:0] chan_exp_r [256];
    logic seen_r [256];
    logic force_r [256];
    logic pkt_start;
    byte_t cur_tag;
    logic [3:0] cur_seq;
    logic [3:0] chan_diff;
    logic chan_miss;
    logic sub_now;
    logic sub_r;
    logic sub;
    logic chan_gap_r;
    byte_t chan_gap_tag_r;
    logic gap_after_loss_r;
    logic [15:0] cnt_value_r;
    logic [15:0] lost_value_r;

    assign pkt_start = (st_r == ST_PAY) && fire && (pay_idx_r == 8'h00);
    assign cur_tag = tag_r[pkt_idx_r];
    assign cur_seq = eseq_r[pkt_idx_r];
    assign chan_diff = cur_seq - chan_exp_r[cur_tag];
    assign chan_miss = seen_r[cur_tag] && (chan_diff != 4'h0);
    assign sub_now = force_r[cur_tag] || (null_on_gap && chan_miss);
    assign sub = (pay_idx_r == 8'h00) ? sub_now : sub_r;

    // channel tables are indexed by the full tag byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 256; i++)
            begin
                pkt_cnt_r[i] <= 16'h0000;
                lost_cnt_r[i] <= 16'h0000;
                chan_exp_r[i] <= 4'h0;
                seen_r[i] <= 1'b0;
                force_r[i] <= 1'b0;
            end
        end
        else
        begin
            if (null_we)
                force_r[null_chan] <= null_force;
            if (pkt_start)
            begin
                pkt_cnt_r[cur_tag] <= pkt_cnt_r[cur_tag] + 16'h0001;
                chan_exp_r[cur_tag] <= cur_seq + 4'h1;
                seen_r[cur_tag] <= 1'b1;
                if (chan_miss)
                    lost_cnt_r[cur_tag] <= lost_cnt_r[cur_tag] + {12'h000, chan_diff};
            end
        end
    end

    // gap report, substitution hold and counter readout
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sub_r <= 1'b0;
            chan_gap_r <= 1'b0;
            chan_gap_tag_r <= 8'h00;
            gap_after_loss_r <= 1'b0;
            cnt_value_r <= 16'h0000;
            lost_value_r <= 16'h0000;
        end
        else
        begin
            chan_gap_r <= pkt_start && chan_miss;
            if (pkt_start)
            begin
                sub_r <= sub_now;
                chan_gap_tag_r <= cur_tag;
                gap_after_loss_r <= loss_pending_r;
            end
            cnt_value_r <= pkt_cnt_r[cnt_sel];
            lost_value_r <= lost_cnt_r[cnt_sel];
        end
    end

    // ----------------------------------------
    // output path through the fifo
    // ----------------------------------------
    byte_t null_byte;
    logic [FW-1:0] wr_word;
    logic [FW-1:0] rd_word;
    logic wr_valid;
    logic wr_last;

    null_ts_rom u_rom
    (
        .idx(pay_idx_r),
        .data(null_byte)
    );

    // an early end of frame closes the packet it cuts short
    assign wr_last = (pay_idx_r == `TS_LAST) || in_last;
    assign wr_valid = (st_r == ST_PAY) && in_valid;
    assign wr_word = {sub, wr_last, (pay_idx_r == 8'h00), cur_tag, sub ? null_byte : in_data};

    ts_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(clk),
        .rst(rst),
        .wr_data(wr_word),
        .wr_valid(wr_valid),
        .wr_ready(fifo_in_ready),
        .rd_data(rd_word),
        .rd_valid(out_valid),
        .rd_ready(out_ready)
    );

    assign {out_is_null, out_last, out_first, out_tag, out_data} = rd_word;
    assign cnt_value = cnt_value_r;
    assign chan_lost_value = lost_value_r;
    assign stream_selector = selector_r;
    assign seq_gap = seq_gap_r;
    assign seq_misorder = seq_misorder_r;
    assign lost_frames = lost_frames_r;
    assign fmt_error = fmt_error_r;
    assign probe_seen = probe_seen_r;
    assign chan_gap = chan_gap_r;
    assign chan_gap_tag = chan_gap_tag_r;
    assign chan_gap_after_loss = gap_after_loss_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence hdr_done_s;
        hdr_end && !in_last;
    endsequence

    sequence bad_total_s;
        hdr_done_s ##0 (htype == `HT_DATA) && ((total == 4'h0) || (total > `MAX_PKTS));
    endsequence

    bad_total_a: assert property (@(posedge clk) disable iff (rst)
        bad_total_s |=> fmt_error && (st_r == ST_DROP))
        else $error("illegal packet total not rejected");

    probe_decode_a: assert property (@(posedge clk) disable iff (rst)
        hdr_end && (htype == `HT_PROBE) |=> probe_seen && (st_r != ST_PAY))
        else $error("latency probe header not decoded");

    seq_check_a: assert property (@(posedge clk) disable iff (rst)
        hdr_done_s ##0 hdr_good && b0_r[`SEQV_BIT] && sess_have_r && (sess_diff != 16'h0000)
        |=> (seq_gap ^ seq_misorder))
        else $error("session sequence break not reported");

    seq_valid_a: assert property (@(posedge clk) disable iff (rst)
        hdr_end && !b0_r[`SEQV_BIT] |=> !seq_gap && !seq_misorder && $stable(lost_frames))
        else $error("sequence checked while marked invalid");

    count_step_a: assert property (@(posedge clk) disable iff (rst)
        pkt_start && (cnt_sel == cur_tag) ##1 (cnt_sel == $past(cur_tag))
        |=> cnt_value == $past(cnt_value, 2) + 16'h0001)
        else $error("channel packet count did not step");

    null_pid_a: assert property (@(posedge clk) disable iff (rst)
        wr_valid && sub && (pay_idx_r == 8'h01) |-> (wr_word[7:0] == 8'h1F))
        else $error("null packet pid byte wrong");

    pay_len_a: assert property (@(posedge clk) disable iff (rst)
        pkt_start && !in_last |=> (st_r == ST_PAY) && (pay_idx_r == 8'h01))
        else $error("payload byte index did not advance");

    entries_a: assert property (@(posedge clk) disable iff (rst)
        (st_r == ST_PAY) |-> (pkt_idx_r < total_r) && (pay_idx_r < `TS_LEN))
        else $error("packet index past announced total");

    drop_a: assert property (@(posedge clk) disable iff (rst)
        (st_r != ST_PAY) |=> $stable(u_fifo.wr_ptr_r))
        else $error("fifo written outside payload");

endmodule

// ---- dv/headend_model.sv ----
// headend core model sending sublayer frames
`timescale 1ns/1ps
module headend_model
(
    input wire logic clk,
    input wire logic in_ready,
    output logic [7:0] in_data,
    output logic in_valid,
    output logic in_last
);
    logic [15:0] sseq = 16'hC35A;
    logic [3:0] chs [256] = '{default: 4'h0};
    logic [7:0] tg [10] = '{default: 8'h00};
    logic junk = 1'b0;

    // idle lines
    initial
    begin
        in_data = 8'h00;
        in_valid = 1'b0;
        in_last = 1'b0;
    end

    // hold the byte until an edge takes it
    task automatic put(input logic [7:0] b, input logic last);
        in_data = b;
        in_valid = 1'b1;
        in_last = last;
        do
            @(posedge clk);
        while (!in_ready);
        #1;
    endtask

    // header, then whole packets; junk fills the unused entries
    task automatic send(input logic sv, input logic [1:0] ht, input logic [2:0] sel, input logic [3:0] tot,
                        input logic dirty);
        logic [7:0] h [24];
        logic ok;
        int np;
        ok = ht == 2'b00 && tot >= 4'h1 && tot <= 4'hA;
        np = ok ? int'(tot) : 1;
        h[0] = {1'b0, sv, ht, dirty, sel};
        h[1] = {dirty ? 4'h9 : 4'h0, tot};
        h[2] = sseq[15:8];
        h[3] = sseq[7:0];
        for (int i = 0; i < 10; i++)
        begin
            h[4 + 2 * i] = (i < np || junk) ? tg[i] : 8'h00;
            h[5 + 2 * i] = (i < np || junk) ? {chs[tg[i]], 4'h0} : 8'h00;
            if (ok && i < np)
                chs[tg[i]] = chs[tg[i]] + 4'h1;
        end
        if (ok)
            sseq = sseq + 16'h1;
        for (int k = 0; k < 24; k++)
            put(h[k], 1'b0);
        for (int p = 0; p < np; p++)
            for (int j = 0; j < 188; j++)
                put(tg[p] + 8'(j), p == np - 1 && j == 187);
        in_valid = 1'b0;
        in_last = 1'b0;
        in_data = ~in_data; // released bus shows the inverse
    endtask
endmodule

// ---- dv/ts_sublayer_rx_test.sv ----
// self-checking bench of the sublayer receiver
`timescale 1ns/1ps
module ts_sublayer_rx_test
    import ts_sublayer_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] in_data;
    logic in_valid;
    logic in_last;
    logic in_ready;
    logic out_ready = 1'b1;
    logic null_on_gap = 1'b0;
    logic null_we = 1'b0;
    logic [7:0] null_chan = 8'h00;
    logic null_force = 1'b0;
    logic [7:0] cnt_sel = 8'h1C;
    logic [7:0] out_data, out_tag, chan_gap_tag;
    logic out_valid, out_first, out_last, out_is_null;
    logic [15:0] cnt_value, chan_lost_value, lost_frames;
    logic [2:0] stream_selector;
    logic seq_gap, seq_misorder, fmt_error, probe_seen, chan_gap, chan_gap_after_loss;
    logic [15:0] n_gap = 16'h0, n_mis = 16'h0, n_fmt = 16'h0, n_prb = 16'h0, n_cg = 16'h0;
    logic [18:0] oq [$];
    logic [8:0] eq [$];
    int fails = 0;
    int n_checks = 0;

    ts_sublayer_rx #(.FIFO_DEPTH(32)) dut (.clk(clk), .rst(rst), .in_data(in_data), .in_valid(in_valid),
        .in_last(in_last), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_first(out_first), .out_last(out_last), .out_tag(out_tag),
        .out_is_null(out_is_null), .null_on_gap(null_on_gap), .null_we(null_we), .null_chan(null_chan),
        .null_force(null_force), .cnt_sel(cnt_sel), .cnt_value(cnt_value), .chan_lost_value(chan_lost_value),
        .stream_selector(stream_selector), .seq_gap(seq_gap), .seq_misorder(seq_misorder),
        .lost_frames(lost_frames), .fmt_error(fmt_error), .probe_seen(probe_seen), .chan_gap(chan_gap),
        .chan_gap_tag(chan_gap_tag), .chan_gap_after_loss(chan_gap_after_loss));
    headend_model pm (.clk(clk), .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid),
        .in_last(in_last));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // capture handed-out bytes and count event pulses
    always @(posedge clk)
    begin
        if (out_valid && out_ready)
            oq.push_back({out_last, out_first, out_is_null, out_tag, out_data});
        n_gap <= n_gap + 16'(seq_gap);
        n_mis <= n_mis + 16'(seq_misorder);
        n_fmt <= n_fmt + 16'(fmt_error);
        n_prb <= n_prb + 16'(probe_seen);
        n_cg <= n_cg + 16'(chan_gap);
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, s, e);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // null packet content by byte index
    function automatic logic [7:0] nb(input int j);
        return j == 0 ? 8'h47 : j == 1 ? 8'h1F : j == 3 ? 8'h10 : 8'hFF;
    endfunction

    // one frame, then one idle cycle
    task automatic fr(input logic sv, input logic [1:0] ht, input logic [2:0] sel, input logic [3:0] tot,
                      input logic dirty);
        pm.send(sv, ht, sel, tot, dirty);
        @(posedge clk);
        #1;
    endtask

    // wait for the packets, then compare each byte
    task automatic drain();
        logic [18:0] w;
        logic [8:0] e;
        int k;
        k = 0;
        while (oq.size() < 188 * eq.size() && k < 30000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (4) @(posedge clk);
        #1;
        check(oq.size(), 188 * eq.size());
        while (eq.size() > 0 && oq.size() >= 188)
        begin
            e = eq.pop_front();
            for (int j = 0; j < 188; j++)
            begin
                w = oq.pop_front();
                check(32'(w), 32'({j == 187, j == 0, e, e[8] ? nb(j) : e[7:0] + 8'(j)}));
            end
        end
        eq.delete();
        oq.delete();
    endtask

    // registered counters lag the selector by one cycle
    task automatic rd(input logic [7:0] t, input logic [15:0] c, input logic [15:0] l);
        cnt_sel = t;
        repeat (2) @(posedge clk);
        #1;
        check(32'(cnt_value), 32'(c));
        check(32'(chan_lost_value), 32'(l));
    endtask

    // ten channels, sink stalled until the buffer refuses
    task automatic t_basic();
        for (int i = 0; i < 10; i++)
        begin
            pm.tg[i] = 8'(3 * i + 1);
            eq.push_back({1'b0, pm.tg[i]});
        end
        out_ready = 1'b0;
        fork
            fr(1'b1, 2'b00, 3'h5, 4'hA, 1'b0);
            begin
                repeat (150) @(posedge clk);
                #1;
                check(32'({in_ready, out_valid}), 32'h1);
                out_ready = 1'b1;
            end
        join
        drain();
        check(32'(stream_selector), 32'h5);
        check(32'(n_fmt), 32'h0);
        rd(8'h1C, 16'h1, 16'h0);
    endtask

    // session gap, misorder and an invalid sequence
    task automatic t_seq();
        logic [15:0] e;
        pm.tg[0] = 8'h40;
        pm.sseq = pm.sseq + 16'h3;
        fr(1'b1, 2'b00, 3'h1, 4'h1, 1'b0);
        e = pm.sseq;
        pm.sseq = e - 16'h8;
        fr(1'b1, 2'b00, 3'h1, 4'h1, 1'b0);
        pm.sseq = 16'h1234;
        fr(1'b0, 2'b00, 3'h1, 4'h1, 1'b0);
        pm.sseq = e;
        fr(1'b1, 2'b00, 3'h1, 4'h1, 1'b0);
        repeat (4) eq.push_back({1'b0, 8'h40});
        drain();
        check(32'({n_gap, n_mis}), {16'h1, 16'h1});
        check(32'(lost_frames), 32'h3);
    endtask

    // bad totals and types dropped; probes only reported
    task automatic t_bad();
        logic [3:0] tt [3] = '{4'h0, 4'hB, 4'hF};
        foreach (tt[i]) fr(1'b1, 2'b00, 3'h2, tt[i], 1'b0);
        fr(1'b1, 2'b10, 3'h2, 4'h1, 1'b0);
        fr(1'b1, 2'b11, 3'h2, 4'h1, 1'b0);
        fr(1'b1, 2'b01, 3'h2, 4'h1, 1'b0);
        pm.tg[0] = 8'h41;
        eq.push_back({1'b0, 8'h41});
        fr(1'b1, 2'b00, 3'h6, 4'h1, 1'b1);
        drain();
        check(32'({n_fmt, n_prb}), {16'h5, 16'h1});
        check(32'(stream_selector), 32'h6);
        check(32'({n_gap, n_mis}), {16'h1, 16'h1});
    endtask

    // channel skips are counted, then nulled
    task automatic t_chan();
        logic [8:0] ev [8] = '{9'h050, 9'h051, 9'h050, 9'h051, 9'h050, 9'h151, 9'h150, 9'h051};
        foreach (ev[i]) eq.push_back(ev[i]);
        pm.tg[0] = 8'h50;
        pm.tg[1] = 8'h51;
        fr(1'b1, 2'b00, 3'h0, 4'h2, 1'b0);
        pm.chs[8'h50] = pm.chs[8'h50] + 4'h2;
        fr(1'b1, 2'b00, 3'h0, 4'h2, 1'b0);
        null_on_gap = 1'b1;
        pm.chs[8'h51] = pm.chs[8'h51] + 4'h3;
        pm.sseq = pm.sseq + 16'h1;
        fr(1'b1, 2'b00, 3'h0, 4'h2, 1'b0);
        null_on_gap = 1'b0;
        check(32'({chan_gap_after_loss, chan_gap_tag}), 32'h151);
        null_chan = 8'h50;
        null_force = 1'b1;
        null_we = 1'b1;
        @(posedge clk);
        #1;
        null_we = 1'b0;
        fr(1'b1, 2'b00, 3'h0, 4'h2, 1'b0);
        drain();
        check(32'(n_cg), 32'h2);
        rd(8'h50, 16'h4, 16'h2);
        rd(8'h51, 16'h4, 16'h3);
    endtask

    // stale entries past the total are ignored
    task automatic t_junk();
        for (int i = 0; i < 10; i++)
            pm.tg[i] = 8'(8'h60 + i);
        pm.junk = 1'b1;
        eq.push_back({1'b0, 8'h60});
        eq.push_back({1'b0, 8'h61});
        fr(1'b1, 2'b00, 3'h3, 4'h2, 1'b0);
        pm.junk = 1'b0;
        drain();
        rd(8'h61, 16'h1, 16'h0);
        rd(8'h62, 16'h0, 16'h0);
        rd(8'h69, 16'h0, 16'h0);
    endtask

    // watchdog: the tests need about six thousand cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        results();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        t_basic();
        t_seq();
        t_bad();
        t_chan();
        t_junk();
        results();
    end
endmodule
